/* logic/aivs_pkg.sv */
package aivs_pkg;
  localparam int AIVS_NSRC = 32;
  localparam int AIVS_ID_W = 5;
  localparam int AIVS_AW = 9;
  localparam logic [8:0] OFF_SVR_BASE = 9'h080;
  localparam logic [8:0] OFF_SVR_LAST = 9'h0fc;
  localparam logic [8:0] OFF_IVR = 9'h100;
  localparam logic [8:0] OFF_FVR = 9'h104;
  localparam logic [8:0] OFF_ISR = 9'h108;
  localparam logic [8:0] OFF_IPR = 9'h10c;
  localparam logic [8:0] OFF_IMR = 9'h110;
  localparam logic [8:0] OFF_CISR = 9'h114;
  localparam logic [8:0] OFF_IECR = 9'h120;
  localparam logic [8:0] OFF_IDCR = 9'h124;
  localparam logic [8:0] OFF_ICCR = 9'h128;
  localparam logic [8:0] OFF_ISCR = 9'h12c;
  localparam logic [8:0] OFF_EOICR = 9'h130;
  localparam logic [8:0] OFF_SPU = 9'h134;
  localparam logic [8:0] OFF_DCR = 9'h138;
  localparam int SVR_IDX_LSB = 2;
  localparam int DCR_LINE_MASK_BIT = 1;
  localparam int DCR_PROT_BIT = 0;
  localparam int CISR_FAST_BIT = 0;
  localparam int CISR_NORM_BIT = 1;
  localparam int FAST_SRC = 0;
  localparam int FIRST_NORM_SRC = 1;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [1:0] RST_DCR = 2'h0;
endpackage

/* logic/aivs_regs.sv */
`timescale 1ns/10ps
// Operation
// - Normal vector read returns the vector of the interrupt being serviced.
// - That vector is picked by the winning pending enabled normal source at read time.
// - With no enabled normal source pending the normal vector read returns spurious vector.
// - Fast vector read returns the vector held for source zero.
// - With no fast interrupt the fast vector read returns spurious vector.
// - Status register low field shows the current source number.
// - Pending register has one bit per source, fast at 0, system at 1.
// - Mask register shows enabled sources, resets to zero.
// - Core status shows fast line in bit 0, normal line in bit 1.
// - Enable command ones enable sources, zeros do nothing.
// - Disable command ones disable sources, zeros do nothing.
// - Clear command ones clear pending sources, zeros do nothing.
// - Set command ones force pending sources, zeros do nothing.
// - Any write to end of service ends current interrupt handling.
// - Spurious vector register is read-write and feeds spurious vector reads.
// - Normal vector read is spurious when no enabled normal source (1 and up) is pending.
// - Global line mask set holds both core lines inactive.
module aivs_regs
  import aivs_pkg::*;
#(
  parameter int NSRC = AIVS_NSRC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_en,
  input wire logic [AIVS_AW-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [NSRC-1:0] source_in,
  output logic normal_irq_line_n,
  output logic fast_irq_line_n
);

  // ==========================================================
  // Bus handshake
  // ==========================================================
  // One wait state: reads are captured on the first edge, the
  // answer and any write take effect on the second.
  logic ack;
  logic rd_take;
  logic wr_take;
  logic [31:0] be_mask;

  assign waitrequest = (read | write) & ~ack;
  assign rd_take = clock_en & read & ~ack;
  assign wr_take = clock_en & write & ack;
  assign be_mask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                    {8{byteenable[1]}}, {8{byteenable[0]}}};

  always_ff @(posedge clock) begin
    if (rst) begin
      ack <= 1'b0;
    end else if (clock_en) begin
      ack <= (read | write) & ~ack;
    end
  end

  // ==========================================================
  // Storage
  // ==========================================================
  logic [31:0] source_vector [NSRC];
  logic [31:0] spurious_vector;
  logic [1:0] debug_ctrl;
  logic [NSRC-1:0] enable_mask;
  logic [NSRC-1:0] pending_flags;
  logic [AIVS_ID_W-1:0] current_source_number;
  logic in_service;
  logic global_line_mask;
  logic wr_svr;
  logic [AIVS_ID_W-1:0] svr_idx;

  assign global_line_mask = debug_ctrl[DCR_LINE_MASK_BIT];
  assign wr_svr = wr_take && address >= OFF_SVR_BASE && address <= OFF_SVR_LAST;
  assign svr_idx = address[SVR_IDX_LSB +: AIVS_ID_W];

  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < NSRC; i++) begin
        source_vector[i] <= RST_WORD;
      end
    end else if (wr_svr) begin
      source_vector[svr_idx] <= (source_vector[svr_idx] & ~be_mask)
                              | (writedata & be_mask);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      spurious_vector <= RST_WORD;
    end else if (wr_take && address == OFF_SPU) begin
      spurious_vector <= (spurious_vector & ~be_mask) | (writedata & be_mask);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      debug_ctrl <= RST_DCR;
    end else if (wr_take && address == OFF_DCR && byteenable[0]) begin
      debug_ctrl <= writedata[1:0];
    end
  end

  // ==========================================================
  // Source selection
  // ==========================================================
  // Fixed priority: lowest numbered normal source wins. Priority
  // levels live outside this block.
  logic [NSRC-1:0] active;
  logic norm_hit;
  logic [AIVS_ID_W-1:0] next_id;
  logic fast_hit;

  assign active = pending_flags & enable_mask;
  assign fast_hit = active[FAST_SRC];

  always_comb begin
    norm_hit = 1'b0;
    next_id = '0;
    for (int i = NSRC - 1; i >= FIRST_NORM_SRC; i--) begin
      if (active[i]) begin
        norm_hit = 1'b1;
        next_id = AIVS_ID_W'(i);
      end
    end
  end

  logic ivr_read;
  logic ivr_ack;
  logic cmd_en;
  logic cmd_dis;
  logic cmd_clr;
  logic cmd_set;

  assign ivr_read = rd_take && address == OFF_IVR;
  assign ivr_ack = ivr_read && norm_hit;
  assign cmd_en = wr_take && address == OFF_IECR;
  assign cmd_dis = wr_take && address == OFF_IDCR;
  assign cmd_clr = wr_take && address == OFF_ICCR;
  assign cmd_set = wr_take && address == OFF_ISCR;

  // ==========================================================
  // Per-source mask and pending
  // ==========================================================
  // A source event or set command in the same cycle as a clear
  // wins, so no edge is lost.
  for (genvar g = 0; g < NSRC; g++) begin : gen_src
    logic ack_this;
    assign ack_this = ivr_ack && next_id == AIVS_ID_W'(g);

    always_ff @(posedge clock) begin
      if (rst) begin
        enable_mask[g] <= 1'b0;
      end else if (cmd_en && writedata[g] && byteenable[g/8]) begin
        enable_mask[g] <= 1'b1;
      end else if (cmd_dis && writedata[g] && byteenable[g/8]) begin
        enable_mask[g] <= 1'b0;
      end
    end

    always_ff @(posedge clock) begin
      if (rst) begin
        pending_flags[g] <= 1'b0;
      end else if (clock_en) begin
        if (source_in[g] || (cmd_set && writedata[g] && byteenable[g/8])) begin
          pending_flags[g] <= 1'b1;
        end else if ((cmd_clr && writedata[g] && byteenable[g/8]) || ack_this) begin
          pending_flags[g] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Service state
  // ==========================================================
  always_ff @(posedge clock) begin
    if (rst) begin
      current_source_number <= '0;
    end else if (ivr_ack) begin
      current_source_number <= next_id;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      in_service <= 1'b0;
    end else if (wr_take && address == OFF_EOICR) begin
      in_service <= 1'b0;
    end else if (ivr_ack) begin
      in_service <= 1'b1;
    end
  end

  // ==========================================================
  // Core lines
  // ==========================================================
  // No nesting: a normal request is held off until end of service.
  always_ff @(posedge clock) begin
    if (rst) begin
      fast_irq_line_n <= 1'b1;
      normal_irq_line_n <= 1'b1;
    end else if (clock_en) begin
      fast_irq_line_n <= ~(fast_hit & ~global_line_mask);
      normal_irq_line_n <= ~(norm_hit & ~in_service & ~global_line_mask);
    end
  end

  // ==========================================================
  // Read data
  // ==========================================================
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = RST_WORD;
    if (address >= OFF_SVR_BASE && address <= OFF_SVR_LAST) begin
      next_rdata = source_vector[svr_idx];
    end else begin
      case (address)
        OFF_IVR: next_rdata = norm_hit ? source_vector[next_id] : spurious_vector;
        OFF_FVR: next_rdata = fast_hit ? source_vector[FAST_SRC] : spurious_vector;
        OFF_ISR: next_rdata = {{(32 - AIVS_ID_W){1'b0}}, current_source_number};
        OFF_IPR: next_rdata = 32'(pending_flags);
        OFF_IMR: next_rdata = 32'(enable_mask);
        OFF_CISR: begin
          next_rdata[CISR_FAST_BIT] = ~fast_irq_line_n;
          next_rdata[CISR_NORM_BIT] = ~normal_irq_line_n;
        end
        OFF_SPU: next_rdata = spurious_vector;
        OFF_DCR: next_rdata = {30'h0, debug_ctrl};
        default: next_rdata = RST_WORD;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      readdata <= RST_WORD;
    end else if (rd_take) begin
      readdata <= next_rdata;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  logic [31:0] past_vec;
  always_ff @(posedge clock) begin
    past_vec <= source_vector[next_id];
  end

  chk_ivr_spurious: assert property (@(posedge clock) disable iff (rst)
    ivr_read && !norm_hit |=> readdata == $past(spurious_vector))
    else $error("normal vector read not spurious");
  chk_ivr_vector: assert property (@(posedge clock) disable iff (rst)
    ivr_read && norm_hit |=> readdata == past_vec && current_source_number == $past(next_id))
    else $error("normal vector read wrong vector");
  chk_fvr_select: assert property (@(posedge clock) disable iff (rst)
    rd_take && address == OFF_FVR |=>
      readdata == ($past(fast_hit) ? $past(source_vector[0]) : $past(spurious_vector)))
    else $error("fast vector read wrong");
  chk_isr_number: assert property (@(posedge clock) disable iff (rst)
    rd_take && address == OFF_ISR |=> readdata[AIVS_ID_W-1:0] == current_source_number)
    else $error("status number wrong");
  chk_enable_cmd: assert property (@(posedge clock) disable iff (rst)
    cmd_en && byteenable == 4'hf |=> (enable_mask & $past(writedata)) == $past(writedata))
    else $error("enable command lost");
  chk_disable_cmd: assert property (@(posedge clock) disable iff (rst)
    cmd_dis && byteenable == 4'hf |=>
      (enable_mask & $past(writedata)) == 32'h0000_0000 &&
      (enable_mask & ~$past(writedata)) == ($past(enable_mask) & ~$past(writedata)))
    else $error("disable command wrong");
  chk_set_cmd: assert property (@(posedge clock) disable iff (rst)
    cmd_set && byteenable == 4'hf |=> (pending_flags & $past(writedata)) == $past(writedata))
    else $error("set command lost");
  chk_clear_cmd: assert property (@(posedge clock) disable iff (rst)
    cmd_clr && byteenable == 4'hf |=> (pending_flags & $past(writedata) & ~$past(source_in))
      == 32'h0000_0000)
    else $error("clear command lost");
  chk_end_service: assert property (@(posedge clock) disable iff (rst)
    wr_take && address == OFF_EOICR |=> !in_service)
    else $error("end of service ignored");
  chk_global_line_mask_lines: assert property (@(posedge clock) disable iff (rst)
    clock_en && global_line_mask |=> fast_irq_line_n && normal_irq_line_n)
    else $error("masked line active");
  chk_wait_one: assert property (@(posedge clock) disable iff (rst)
    clock_en && (read || write) && !ack |=> !waitrequest)
    else $error("wait state not one cycle");
  // A master may take read data late, so it must not move between reads
  chk_rdata_hold: assert property (@(posedge clock) disable iff (rst)
    !rd_take |=> $stable(readdata))
    else $error("read data moved without a read");
  chk_core_status: assert property (@(posedge clock) disable iff (rst)
    rd_take && address == OFF_CISR |=>
      readdata[CISR_FAST_BIT] == !$past(fast_irq_line_n) &&
      readdata[CISR_NORM_BIT] == !$past(normal_irq_line_n))
    else $error("core status does not match lines");
  chk_pending_read: assert property (@(posedge clock) disable iff (rst)
    rd_take && address == OFF_IPR |=> readdata == 32'($past(pending_flags)))
    else $error("pending read wrong");
  chk_mask_read: assert property (@(posedge clock) disable iff (rst)
    rd_take && address == OFF_IMR |=> readdata == 32'($past(enable_mask)))
    else $error("mask read wrong");
  chk_svr_read: assert property (@(posedge clock) disable iff (rst)
    rd_take && address >= OFF_SVR_BASE && address <= OFF_SVR_LAST |=>
      readdata == $past(source_vector[svr_idx]))
    else $error("source vector read wrong");
  chk_vector_write: assert property (@(posedge clock) disable iff (rst)
    wr_svr && byteenable == 4'hf |=> source_vector[$past(svr_idx)] == $past(writedata))
    else $error("source vector write lost");
  chk_spurious_write: assert property (@(posedge clock) disable iff (rst)
    wr_take && address == OFF_SPU && byteenable == 4'hf |=>
      spurious_vector == $past(writedata))
    else $error("spurious vector write lost");

  // ==========================================================
  // State checks
  // ==========================================================
  chk_mask_reset: assert property (@(posedge clock) disable iff (rst)
    $past(rst) |-> enable_mask == '0 && pending_flags == '0)
    else $error("mask or pending not cleared by reset");
  chk_lines_reset: assert property (@(posedge clock) disable iff (rst)
    $past(rst) |-> fast_irq_line_n && normal_irq_line_n)
    else $error("core line active after reset");
  // A level on a source must reach pending even while its mask is off
  chk_source_pend: assert property (@(posedge clock) disable iff (rst)
    clock_en |=> (pending_flags & $past(source_in)) == $past(source_in))
    else $error("source level not pending");
  // Clock enable low must freeze the handshake too, or a stalled
  // request would be taken twice
  chk_freeze_state: assert property (@(posedge clock) disable iff (rst)
    !clock_en |=> $stable(enable_mask) && $stable(pending_flags) && $stable(ack) &&
      $stable(in_service) && $stable(current_source_number) && $stable(readdata) &&
      $stable(fast_irq_line_n) && $stable(normal_irq_line_n))
    else $error("state moved while clock enable low");
  chk_service_set: assert property (@(posedge clock) disable iff (rst)
    ivr_ack |=> in_service)
    else $error("vector read did not start service");
  chk_pending_ack: assert property (@(posedge clock) disable iff (rst)
    ivr_ack && !source_in[next_id] |=> !pending_flags[$past(next_id)])
    else $error("serviced source still pending");
  chk_fvr_quiet: assert property (@(posedge clock) disable iff (rst)
    rd_take && address == OFF_FVR |=> $stable(current_source_number) && $stable(in_service))
    else $error("fast vector read changed service state");
  chk_spurious_keep: assert property (@(posedge clock) disable iff (rst)
    ivr_read && !norm_hit |=> $stable(current_source_number) && $stable(in_service))
    else $error("spurious read changed service state");
  chk_normal_held: assert property (@(posedge clock) disable iff (rst)
    clock_en && in_service |=> normal_irq_line_n)
    else $error("normal line active during service");
  chk_fast_follow: assert property (@(posedge clock) disable iff (rst)
    clock_en && !global_line_mask |=> fast_irq_line_n == !$past(fast_hit))
    else $error("fast line does not follow fast source");

  // ==========================================================
  // Coverage
  // ==========================================================
  cov_vector_read: cover property (@(posedge clock) disable iff (rst) ivr_ack);
  cov_spurious_read: cover property (@(posedge clock) disable iff (rst) ivr_read && !norm_hit);
  cov_full_service: cover property (@(posedge clock) disable iff (rst)
    ivr_ack ##[1:50] (wr_take && address == OFF_EOICR));
  cov_fast_line: cover property (@(posedge clock) disable iff (rst) !fast_irq_line_n);
  cov_frozen_source: cover property (@(posedge clock) disable iff (rst) !clock_en && |source_in);

endmodule

/* testbench/aivs_core_model.sv */
`timescale 1ns/10ps
// ==========
// Core side: latches the active-low lines as active-high flags
module aivs_core_model (
  input wire logic clock,
  input wire logic normal_irq_line_n,
  input wire logic fast_irq_line_n,
  output logic [1:0] taken
);
  always_ff @(posedge clock) begin
    taken <= {~normal_irq_line_n, ~fast_irq_line_n};
  end
endmodule

/* testbench/tb_top.sv */
`timescale 1ns/10ps
module tb_top
  import aivs_pkg::*;
;
  logic clock, rst, read, write;
  logic [8:0] address;
  logic [31:0] writedata, readdata, source_in, rd;
  logic waitrequest, nl_n, fl_n;
  logic ce;
  logic [3:0] be;
  logic [1:0] taken;
  logic [31:0] m_mask, m_pend, m_spu;
  logic [31:0] m_svr [32];
  logic m_gm, m_svc;
  int m_cur, miscompares, n_tests;

  aivs_regs i_aivs_regs (.clock(clock), .rst(rst), .clock_en(ce), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(be),
    .readdata(readdata), .waitrequest(waitrequest), .source_in(source_in),
    .normal_irq_line_n(nl_n), .fast_irq_line_n(fl_n));
  aivs_core_model i_aivs_core_model (.clock(clock), .normal_irq_line_n(nl_n),
    .fast_irq_line_n(fl_n), .taken(taken));

  // ==========
  // Bus master and reference model
  task automatic complete_run();
    $display("counts: compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic bus(input logic wr_en, input logic [8:0] a, input logic [31:0] d);
    int k;
    @(posedge clock);
    read <= !wr_en;
    write <= wr_en;
    address <= a;
    writedata <= d;
    // Waitrequest and read data are taken at the rising edge that ends the wait
    for (k = 0; k < 20; k++) begin
      @(posedge clock);
      if (waitrequest === 1'b0) break;
    end
    if (k == 20) begin
      miscompares++;
      complete_run();
    end
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    logic [31:0] bm;
    bus(1'b1, a, d);
    // Lanes are those that stood on the bus when the write landed
    bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    case (a)
      OFF_IECR: m_mask |= d & bm;
      OFF_IDCR: m_mask &= ~(d & bm);
      OFF_ICCR: m_pend &= ~(d & bm);
      OFF_ISCR: m_pend |= d & bm;
      OFF_EOICR: m_svc = 1'b0;
      OFF_SPU: m_spu = (m_spu & ~bm) | (d & bm);
      OFF_DCR: if (be[0]) m_gm = d[DCR_LINE_MASK_BIT];
      default: if (a >= OFF_SVR_BASE && a <= OFF_SVR_LAST) begin
        m_svr[a[6:2]] = (m_svr[a[6:2]] & ~bm) | (d & bm);
      end
    endcase
  endtask

  task automatic chk_reg(input logic [8:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    n_tests++;
    if (rd !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t reg %h got %h exp %h", $time, a, rd, e);
    end
  endtask

  function automatic logic [1:0] lines_exp();
    logic [1:0] e;
    e[0] = m_pend[0] & m_mask[0] & !m_gm;
    e[1] = (|(m_pend & m_mask & 32'hffff_fffe)) & !m_svc & !m_gm;
    return e;
  endfunction

  task automatic chk_line();
    // Lines are registered one cycle behind state, the core samples one more
    repeat (3) @(posedge clock);
    n_tests++;
    if (taken !== lines_exp()) begin
      miscompares++;
      $display("[FAIL] t=%0t lines got %h exp %h", $time, taken, lines_exp());
    end
    chk_reg(OFF_CISR, {30'h0, lines_exp()});
  endtask

  task automatic chk_ivr();
    int w;
    logic [31:0] e;
    w = 0;
    for (int i = 31; i >= 1; i--) if (m_pend[i] & m_mask[i]) w = i;
    e = (w != 0) ? m_svr[w] : m_spu;
    chk_reg(OFF_IVR, e);
    if (w != 0) begin
      m_cur = w;
      m_pend[w] = 1'b0;
      m_svc = 1'b1;
    end
    chk_reg(OFF_ISR, {27'h0, 5'(m_cur)});
  endtask

  task automatic chk_fvr();
    chk_reg(OFF_FVR, (m_pend[0] & m_mask[0]) ? m_svr[0] : m_spu);
  endtask

  // ==========
  // Stimulus
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  initial begin
    rst = 1'b1; read = 1'b0; write = 1'b0; address = 9'h0;
    writedata = 32'h0; source_in = 32'h0;
    ce = 1'b1;
    be = 4'hf;
    m_mask = 32'h0; m_pend = 32'h0; m_spu = 32'h0; m_gm = 1'b0; m_svc = 1'b0;
    m_cur = 0; miscompares = 0; n_tests = 0;
    for (int i = 0; i < 32; i++) m_svr[i] = 32'h0;
    void'($urandom(32'h02147623));
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    chk_reg(OFF_IMR, 32'h0);
    chk_reg(OFF_IPR, 32'h0);
    chk_fvr();
    $display("test reset values done");
    for (int i = 0; i < 32; i++) wr(OFF_SVR_BASE + 9'(4 * i), $urandom);
    wr(OFF_SPU, $urandom);
    chk_reg(OFF_SPU, m_spu);
    be <= 4'h1;
    wr(OFF_SPU, $urandom);
    be <= 4'hf;
    chk_reg(OFF_SPU, m_spu);
    chk_reg(OFF_SVR_BASE + 9'h14, m_svr[5]);
    chk_ivr();
    wr(9'h118, 32'hffff_ffff);
    chk_reg(9'h118, 32'h0);
    $display("test spurious done");
    for (int n = 0; n < 3; n++) begin
      wr(OFF_ISCR, $urandom);
      chk_reg(OFF_IPR, m_pend);
      wr(OFF_ICCR, $urandom);
      chk_reg(OFF_IPR, m_pend);
      wr(OFF_IECR, $urandom);
      chk_reg(OFF_IMR, m_mask);
      wr(OFF_IDCR, $urandom & $urandom);
      chk_reg(OFF_IMR, m_mask);
      chk_line();
      repeat (3) begin
        chk_ivr();
        chk_line();
        wr(OFF_EOICR, $urandom);
        chk_line();
      end
    end
    $display("test commands and vectors done");
    wr(OFF_IECR, 32'h1);
    wr(OFF_ISCR, 32'h1);
    chk_fvr();
    chk_line();
    wr(OFF_IECR, 32'h4);
    wr(OFF_ISCR, 32'h4);
    wr(OFF_DCR, 32'h2);
    chk_line();
    wr(OFF_DCR, 32'h0);
    chk_line();
    chk_reg(OFF_DCR, 32'h0);
    $display("test fast and mask done");
    @(posedge clock);
    source_in <= 32'h0000_0200;
    @(posedge clock);
    source_in <= 32'h0;
    m_pend[9] = 1'b1;
    chk_reg(OFF_IPR, m_pend);
    $display("test source input done");
    ce <= 1'b0;
    source_in <= 32'h0000_0400;
    repeat (3) @(posedge clock);
    ce <= 1'b1;
    source_in <= 32'h0;
    chk_reg(OFF_IPR, m_pend);
    $display("test clock enable done");
    complete_run();
  end
endmodule
